// file: rtl/output_mismatch_checker.sv
`include "mismatch_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module output_mismatch_checker #(
	parameter int DATA_W = `DATA_LINES,
	parameter int REPLY_W = `REPLY_LINES,
	parameter bit DUAL_EDGE = `VARIANT_SINGLE
) (
	input wire logic mclk_i,                            // Device clock, 40 MHz
	input wire logic rstn_i,                            // Synchronous reset, active low
	input wire logic local_bus_checker_select_i,        // High selects checker operation
	input wire logic [DATA_W-1:0] data_int_i,           // Internally computed data
	input wire logic [DATA_W-1:0] data_act_i,           // Data lines the core drives
	input wire logic [REPLY_W-1:0] reply_int_i,         // Internally computed reply
	input wire logic [REPLY_W-1:0] reply_act_i,         // Reply lines the core drives
	input wire logic [DATA_W-1:0] local_bus_data_lines_i,   // Data pin levels
	input wire logic [REPLY_W-1:0] local_bus_reply_lines_i, // Reply pin levels
	output logic [DATA_W-1:0] local_bus_data_lines_o,       // Data pin drive value
	output logic [DATA_W-1:0] local_bus_data_lines_oe_o,    // Data pin drive enable
	output logic [REPLY_W-1:0] local_bus_reply_lines_o,     // Reply pin drive value
	output logic [REPLY_W-1:0] local_bus_reply_lines_oe_o,  // Reply pin drive enable
	output mismatch_pkg::mode_type mode_o,                  // Current bus role
	output logic err_o                                      // Mismatch error
);
	import mismatch_pkg::*;

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [DATA_W-1:0] data_r, data_nxt;
	logic [DATA_W-1:0] data_act_r, data_act_nxt;
	logic [REPLY_W-1:0] reply_rise_r, reply_rise_nxt;
	logic [REPLY_W-1:0] reply_fall_r, reply_fall_nxt;
	logic [REPLY_W-1:0] reply_act_rise_r, reply_act_rise_nxt;
	logic [REPLY_W-1:0] reply_act_fall_r, reply_act_fall_nxt;
	logic rise_smp_r, rise_smp_nxt;
	logic eval_r, eval_nxt;
	logic fall_smp_r, fall_smp_nxt;
	logic err_r, err_nxt;
	mode_type mode_r, mode_nxt;

	logic [REPLY_W-1:0] reply_drv;
	logic [REPLY_W-1:0] reply_act;
	logic data_mis;
	logic reply_mis;
	logic rise_mis;

	assign reply_drv = DUAL_EDGE ? reply_fall_r : reply_rise_r;
	assign reply_act = DUAL_EDGE ? reply_act_fall_r : reply_act_rise_r;

	// ------------------------------------------------------------------------
	// Comparators
	// ------------------------------------------------------------------------
	// Own intention is compared in both roles, so a checker sees the master
	pin_compare #(.WIDTH(DATA_W)) u_data_cmp (
		.intended_i(data_r),
		.observed_i(local_bus_data_lines_i),
		.active_i(data_act_r),
		.mismatch_o(data_mis)
	);

	pin_compare #(.WIDTH(REPLY_W)) u_reply_cmp (
		.intended_i(reply_drv),
		.observed_i(local_bus_reply_lines_i),
		.active_i(reply_act),
		.mismatch_o(reply_mis)
	);

	// Single-edge checks every line at the rising edge
	assign rise_mis = DUAL_EDGE ? data_mis : (data_mis | reply_mis);

	// ------------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------------
	assign local_bus_data_lines_o = data_r;
	assign local_bus_reply_lines_o = reply_drv;
	assign local_bus_data_lines_oe_o = (mode_r == MODE_CHECKER) ? '0 : data_act_r;
	assign local_bus_reply_lines_oe_o = (mode_r == MODE_CHECKER) ? '0 : reply_act;
	assign mode_o = mode_r;
	assign err_o = err_r;

	// ------------------------------------------------------------------------
	// Rising edge group
	// ------------------------------------------------------------------------
	always_comb begin
		data_nxt = data_int_i;
		data_act_nxt = data_act_i;
		reply_rise_nxt = reply_int_i;
		reply_act_rise_nxt = reply_act_i;
		rise_smp_nxt = rise_mis;
		eval_nxt = rise_smp_r | fall_smp_r;
		if (!rstn_i) begin
			data_nxt = '0;
			data_act_nxt = '0;
			reply_rise_nxt = '0;
			reply_act_rise_nxt = '0;
			rise_smp_nxt = `SMP_RESET;
			eval_nxt = `SMP_RESET;
		end
	end

	always_ff @(posedge mclk_i) begin
		data_r <= data_nxt;
		data_act_r <= data_act_nxt;
		reply_rise_r <= reply_rise_nxt;
		reply_act_rise_r <= reply_act_rise_nxt;
		rise_smp_r <= rise_smp_nxt;
		eval_r <= eval_nxt;
	end

	// ------------------------------------------------------------------------
	// Falling edge group
	// ------------------------------------------------------------------------
	always_comb begin
		mode_nxt = local_bus_checker_select_i ? MODE_CHECKER : MODE_MASTER;
		reply_fall_nxt = reply_int_i;
		reply_act_fall_nxt = reply_act_i;
		fall_smp_nxt = reply_mis;
		// Result of the last evaluation only; nothing is held over
		err_nxt = DUAL_EDGE ? eval_r : rise_smp_r;
		if (!rstn_i) begin
			mode_nxt = MODE_MASTER;
			reply_fall_nxt = '0;
			reply_act_fall_nxt = '0;
			fall_smp_nxt = `SMP_RESET;
			err_nxt = `ERR_RESET;
		end
	end

	always_ff @(negedge mclk_i) begin
		mode_r <= mode_nxt;
		reply_fall_r <= reply_fall_nxt;
		reply_act_fall_r <= reply_act_fall_nxt;
		fall_smp_r <= fall_smp_nxt;
		err_r <= err_nxt;
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	generate
		if (!DUAL_EDGE) begin : g_single_chk
			property p_err_single;
				@(posedge mclk_i) disable iff (!rstn_i)
				$past(rstn_i) |-> err_o == $past(rise_mis);
			endproperty
			a_err_single: assert property (p_err_single) else $error("error output does not follow rising compare");

			property p_err_next_rise;
				@(posedge mclk_i) disable iff (!rstn_i)
				rise_mis |=> err_o;
			endproperty
			a_err_next_rise: assert property (p_err_next_rise) else $error("mismatch not flagged by next rising edge");

			property p_err_on_fall;
				@(negedge mclk_i) disable iff (!rstn_i)
				$past(rstn_i) |-> err_o == $past(rise_smp_r);
			endproperty
			a_err_on_fall: assert property (p_err_on_fall) else $error("error not driven from falling edge");

			property p_stuck_low;
				@(posedge mclk_i) disable iff (!rstn_i)
				(|(data_act_r & data_r & ~local_bus_data_lines_i)) |=> err_o;
			endproperty
			a_stuck_low: assert property (p_stuck_low) else $error("line held low while driven high not flagged");

			property p_checker_err;
				@(posedge mclk_i) disable iff (!rstn_i)
				(mode_r == MODE_CHECKER && rise_mis) |=> err_o;
			endproperty
			a_checker_err: assert property (p_checker_err) else $error("checker missed master difference");

			property p_no_latch;
				@(posedge mclk_i) disable iff (!rstn_i)
				(!rise_mis && $past(rstn_i)) |=> !err_o;
			endproperty
			a_no_latch: assert property (p_no_latch) else $error("error held without mismatch");

			c_single_err: cover property (@(posedge mclk_i) disable iff (!rstn_i) rise_mis ##1 err_o ##1 !err_o);
		end else begin : g_dual_chk
			property p_dual_eval;
				@(posedge mclk_i) disable iff (!rstn_i)
				$past(rstn_i, 3) |-> err_o == ($past(data_mis, 2) | $past(fall_smp_r, 1));
			endproperty
			a_dual_eval: assert property (p_dual_eval) else $error("dual-edge error differs from collected samples");

			property p_reply_fall;
				@(negedge mclk_i) disable iff (!rstn_i)
				$past(rstn_i) |-> fall_smp_r == $past(reply_mis);
			endproperty
			a_reply_fall: assert property (p_reply_fall) else $error("reply lines not sampled at falling edge");

			property p_dual_drive;
				@(negedge mclk_i) disable iff (!rstn_i)
				$past(rstn_i) |-> err_o == $past(eval_r);
			endproperty
			a_dual_drive: assert property (p_dual_drive) else $error("evaluation not driven at falling edge");

			c_dual_err: cover property (@(posedge mclk_i) disable iff (!rstn_i) fall_smp_r ##2 err_o);
		end
	endgenerate

	property p_sel_sample;
		@(negedge mclk_i) disable iff (!rstn_i)
		$past(rstn_i) |-> (mode_r == MODE_CHECKER) == $past(local_bus_checker_select_i);
	endproperty
	a_sel_sample: assert property (p_sel_sample) else $error("checker select not sampled at falling edge");

	property p_checker_quiet;
		@(posedge mclk_i) disable iff (!rstn_i)
		mode_r == MODE_CHECKER |-> (local_bus_data_lines_oe_o == '0 && local_bus_reply_lines_oe_o == '0);
	endproperty
	a_checker_quiet: assert property (p_checker_quiet) else $error("checker drives bus lines");

	c_enter_checker: cover property (@(posedge mclk_i) disable iff (!rstn_i) mode_r == MODE_MASTER ##1 mode_r == MODE_CHECKER);
	c_checker_err: cover property (@(posedge mclk_i) disable iff (!rstn_i) mode_r == MODE_CHECKER && err_o);

endmodule : output_mismatch_checker

`default_nettype wire

// file: rtl/mismatch_regs.svh
`ifndef MISMATCH_REGS_SVH
`define MISMATCH_REGS_SVH

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ERR_RESET 1'h0
`define SMP_RESET 1'h0
`define SEL_RESET 1'h0

// ----------------------------------------------------------------------------
// Widths and variants
// ----------------------------------------------------------------------------
`define DATA_LINES 32
`define REPLY_LINES 2
`define VARIANT_SINGLE 1'h0
`define VARIANT_DUAL 1'h1

`endif

// file: rtl/mismatch_pkg.sv
package mismatch_pkg;

	// ------------------------------------------------------------------------
	// Bus role, from the checker select input
	// ------------------------------------------------------------------------
	typedef enum logic {
		MODE_MASTER,
		MODE_CHECKER
	} mode_type;

endpackage : mismatch_pkg

// file: rtl/pin_compare.sv
`timescale 1ns/100ps
`default_nettype none

module pin_compare #(
	parameter int WIDTH = 32
) (
	input wire logic [WIDTH-1:0] intended_i, // Value the device means to drive
	input wire logic [WIDTH-1:0] observed_i, // Level seen on the pins
	input wire logic [WIDTH-1:0] active_i,   // Lines actively driven
	output logic mismatch_o                  // Any active line disagrees
);

	logic [WIDTH-1:0] bit_diff;

	// ------------------------------------------------------------------------
	// One comparator per line
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_line
			assign bit_diff[g] = active_i[g] & (intended_i[g] ^ observed_i[g]);
		end
	endgenerate

	assign mismatch_o = |bit_diff;

endmodule : pin_compare

`default_nettype wire

// file: tb/master_bus_model.sv
`timescale 1ns/100ps
`default_nettype none

module master_bus_model (
	input wire logic clk_i,             // Device clock
	input wire logic master_on_i,       // Model acts as bus master on the shared pins
	input wire logic [31:0] m_data_i,   // Master data value
	input wire logic [1:0] m_reply_i,   // Master reply value
	input wire logic [31:0] d_o_i,      // Device data drive value
	input wire logic [31:0] d_oe_i,     // Device data drive enable
	input wire logic [1:0] r_o_i,       // Device reply drive value
	input wire logic [1:0] r_oe_i,      // Device reply drive enable
	input wire logic [31:0] d_short_i,  // Data lines shorted to ground
	input wire logic [1:0] r_short_i,   // Reply lines shorted to ground
	output logic [31:0] d_pin_o,        // Resolved data pin level
	output logic [1:0] r_pin_o          // Resolved reply pin level
);
	logic [31:0] md_r;
	logic [1:0] mr_r;
	logic float_r = 1'b0;

	// Master launches its outputs off the rising edge, as the device launches its data lines
	always @(posedge clk_i) begin
		md_r <= m_data_i;
		mr_r <= m_reply_i;
		float_r <= ~float_r;
	end

	// Undriven lines show a pattern that changes every cycle; a short wins over any driver
	assign d_pin_o = ~d_short_i & ((d_oe_i & d_o_i) | (~d_oe_i & (master_on_i ? md_r : {16{float_r, ~float_r}})));
	assign r_pin_o = ~r_short_i & ((r_oe_i & r_o_i) | (~r_oe_i & (master_on_i ? mr_r : {float_r, ~float_r})));
endmodule : master_bus_model

`default_nettype wire

// file: tb/output_mismatch_checker_test.sv
`timescale 1ns/100ps
`default_nettype none

module output_mismatch_checker_test;
	import mismatch_pkg::*;
	localparam logic [31:0] VAL = 32'hA5A5_5A5A;
	logic clk, rstn, sel, m_on, err;
	logic [31:0] d_int, d_act, d_pin, d_o, d_oe, m_data, d_short;
	logic [1:0] r_int, r_act, r_pin, r_o, r_oe, m_reply, r_short;
	mode_type mode;
	logic err_dual;
	logic [31:0] d_pin_dual, d_o_dual, d_oe_dual;
	logic [1:0] r_pin_dual, r_o_dual, r_oe_dual;
	mode_type mode_dual;
	int bad_count, checks;

	output_mismatch_checker output_mismatch_checker_inst (.mclk_i(clk), .rstn_i(rstn),
		.local_bus_checker_select_i(sel), .data_int_i(d_int), .data_act_i(d_act), .reply_int_i(r_int),
		.reply_act_i(r_act), .local_bus_data_lines_i(d_pin), .local_bus_reply_lines_i(r_pin),
		.local_bus_data_lines_o(d_o), .local_bus_data_lines_oe_o(d_oe), .local_bus_reply_lines_o(r_o),
		.local_bus_reply_lines_oe_o(r_oe), .mode_o(mode), .err_o(err));

	master_bus_model master_bus_model_inst (.clk_i(clk), .master_on_i(m_on), .m_data_i(m_data),
		.m_reply_i(m_reply), .d_o_i(d_o), .d_oe_i(d_oe), .r_o_i(r_o), .r_oe_i(r_oe),
		.d_short_i(d_short), .r_short_i(r_short), .d_pin_o(d_pin), .r_pin_o(r_pin));

	// Dual-edge variant on its own copy of the bus, fed the same stimulus
	output_mismatch_checker #(.DUAL_EDGE(1'h1)) output_mismatch_checker_dual_inst (.mclk_i(clk), .rstn_i(rstn),
		.local_bus_checker_select_i(sel), .data_int_i(d_int), .data_act_i(d_act), .reply_int_i(r_int),
		.reply_act_i(r_act), .local_bus_data_lines_i(d_pin_dual), .local_bus_reply_lines_i(r_pin_dual),
		.local_bus_data_lines_o(d_o_dual), .local_bus_data_lines_oe_o(d_oe_dual),
		.local_bus_reply_lines_o(r_o_dual), .local_bus_reply_lines_oe_o(r_oe_dual),
		.mode_o(mode_dual), .err_o(err_dual));

	master_bus_model master_bus_dual_inst (.clk_i(clk), .master_on_i(m_on), .m_data_i(m_data),
		.m_reply_i(m_reply), .d_o_i(d_o_dual), .d_oe_i(d_oe_dual), .r_o_i(r_o_dual), .r_oe_i(r_oe_dual),
		.d_short_i(d_short), .r_short_i(r_short), .d_pin_o(d_pin_dual), .r_pin_o(r_pin_dual));

	always #12.5 clk = ~clk;

	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task rise(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : rise

	task set_bus(input logic [31:0] d, input logic [31:0] da, input logic [1:0] r, input logic [1:0] ra);
		@(negedge clk);
		d_int <= d;
		d_act <= da;
		r_int <= r;
		r_act <= ra;
	endtask : set_bus

	task t_plain;
		set_bus(VAL, 32'hFFFF_FFFF, 2'h2, 2'h3);
		rise(3);
		check("err", 32'h0, {31'h0, err});
		check("data_oe", 32'hFFFF_FFFF, d_oe);
		check("data_drive", VAL, d_o);
		check("reply_drive", 32'h2, {30'h0, r_o});
		$display("test plain done");
	endtask : t_plain

	task t_short(input logic [31:0] ds, input logic [1:0] rs);
		@(negedge clk);
		d_short <= ds;
		r_short <= rs;
		rise(1);
		check("err_before", 32'h0, {31'h0, err});
		rise(1);
		check("err_raised", 32'h1, {31'h0, err});
		@(negedge clk);
		d_short <= 32'h0;
		r_short <= 2'h0;
		rise(1);
		check("err_held", 32'h1, {31'h0, err});
		rise(1);
		check("err_cleared", 32'h0, {31'h0, err});
		$display("test short done");
	endtask : t_short

	task t_dual(input logic [31:0] ds, input logic [1:0] rs);
		@(negedge clk);
		d_short <= ds;
		r_short <= rs;
		rise(2);
		check("err_single_lead", 32'h1, {31'h0, err});
		check("err_dual_wait", 32'h0, {31'h0, err_dual});
		rise(1);
		check("err_dual_raised", 32'h1, {31'h0, err_dual});
		@(negedge clk);
		d_short <= 32'h0;
		r_short <= 2'h0;
		rise(2);
		check("err_dual_held", 32'h1, {31'h0, err_dual});
		rise(1);
		check("err_dual_cleared", 32'h0, {31'h0, err_dual});
		check("reply_drive_dual", 32'h2, {30'h0, r_o_dual});
		check("reply_oe_dual", 32'h3, {30'h0, r_oe_dual});
		$display("test dual done");
	endtask : t_dual

	task t_inactive;
		set_bus(VAL, 32'hFFFF_0000, 2'h2, 2'h0);
		rise(1);
		// Shorts land only once the lines are no longer driven
		@(negedge clk);
		d_short <= 32'h0000_FFFF;
		r_short <= 2'h3;
		rise(2);
		check("err_mid", 32'h0, {31'h0, err});
		check("err_dual_mid", 32'h0, {31'h0, err_dual});
		rise(1);
		check("err", 32'h0, {31'h0, err});
		check("err_dual", 32'h0, {31'h0, err_dual});
		check("data_oe", 32'hFFFF_0000, d_oe);
		check("reply_oe", 32'h0, {30'h0, r_oe});
		@(negedge clk);
		d_short <= 32'h0;
		r_short <= 2'h0;
		set_bus(VAL, 32'hFFFF_FFFF, 2'h2, 2'h3);
		rise(3);
		$display("test inactive done");
	endtask : t_inactive

	task t_checker;
		@(negedge clk);
		sel <= 1'b1;
		m_on <= 1'b1;
		m_data <= VAL;
		m_reply <= 2'h2;
		rise(1);
		check("mode_early", 32'h0, {31'h0, mode});
		rise(1);
		check("mode_checker", 32'h1, {31'h0, mode});
		check("mode_checker_dual", 32'h1, {31'h0, mode_dual});
		check("data_oe_dual", 32'h0, d_oe_dual);
		check("data_oe", 32'h0, d_oe);
		check("reply_oe", 32'h0, {30'h0, r_oe});
		rise(2);
		check("err_agree", 32'h0, {31'h0, err});
		@(negedge clk);
		m_data <= VAL ^ 32'h0000_0100;
		rise(3);
		check("err_master", 32'h1, {31'h0, err});
		@(negedge clk);
		m_data <= VAL;
		rise(3);
		check("err_back", 32'h0, {31'h0, err});
		@(negedge clk);
		sel <= 1'b0;
		@(negedge clk);
		m_on <= 1'b0;
		rise(1);
		check("mode_master", 32'h0, {31'h0, mode});
		check("data_oe", 32'hFFFF_FFFF, d_oe);
		rise(2);
		check("err_final", 32'h0, {31'h0, err});
		$display("test checker done");
	endtask : t_checker

	task finish_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	initial begin
		#100_000;
		bad_count++;
		finish_test;
	end

	initial begin
		{clk, rstn, sel, m_on, d_int, d_act, r_int, r_act} = '0;
		{m_data, m_reply, d_short, r_short, bad_count, checks} = '0;
		rise(6);
		check("reset_err", 32'h0, {31'h0, err});
		check("reset_mode", 32'h0, {31'h0, mode});
		check("reset_oe", 32'h0, d_oe);
		check("reset_err_dual", 32'h0, {31'h0, err_dual});
		@(negedge clk);
		rstn <= 1'b1;
		t_plain;
		t_short(32'h0000_0002, 2'h0);
		t_short(32'h0, 2'h2);
		t_dual(32'h0000_0002, 2'h0);
		t_dual(32'h0, 2'h2);
		t_inactive;
		t_checker;
		finish_test;
	end
endmodule : output_mismatch_checker_test

`default_nettype wire
